// ### verilog/eag_pkg.sv
// Shared types and constants of the effective address generator.
// Assumes an 8-bit core with a 16-bit address bus and one machine clock.

package eag_pkg;

  // ****************************************************************
  // Widths and fixed figures
  // ****************************************************************
  localparam int          ADDR_W      = 16;        // Address bus width
  localparam int          DATA_W      = 8;         // Data bus width
  localparam logic [1:0]  LEN_ONE     = 2'h1;      // One-byte instruction
  localparam logic [1:0]  LEN_TWO     = 2'h2;      // Two-byte instruction
  localparam logic [1:0]  LEN_THREE   = 2'h3;      // Three-byte instruction

  // ****************************************************************
  // Opcode map rows (high nibble)
  // ****************************************************************
  localparam logic [3:0]  ROW_BTB     = 4'h0;      // Bit test and branch
  localparam logic [3:0]  ROW_BSC     = 4'h1;      // Bit set / clear
  localparam logic [3:0]  ROW_REL     = 4'h2;      // Relative branches
  localparam logic [3:0]  ROW_RMW_DIR = 4'h3;      // Modify, direct
  localparam logic [3:0]  ROW_RMW_A   = 4'h4;      // Modify, accumulator
  localparam logic [3:0]  ROW_RMW_X   = 4'h5;      // Modify, index
  localparam logic [3:0]  ROW_RMW_IX1 = 4'h6;      // Modify, indexed 8-bit
  localparam logic [3:0]  ROW_RMW_IX0 = 4'h7;      // Modify, indexed plain
  localparam logic [3:0]  ROW_CTL_LO  = 4'h8;      // Control, first row
  localparam logic [3:0]  ROW_CTL_HI  = 4'h9;      // Control, second row
  localparam logic [3:0]  ROW_IMM     = 4'ha;      // Register/memory rows
  localparam logic [3:0]  ROW_DIR     = 4'hb;
  localparam logic [3:0]  ROW_EXT     = 4'hc;
  localparam logic [3:0]  ROW_IX2     = 4'hd;
  localparam logic [3:0]  ROW_IX1     = 4'he;
  localparam logic [3:0]  ROW_IX0     = 4'hf;

  // ****************************************************************
  // Opcode map columns (low nibble) with special meaning
  // ****************************************************************
  localparam logic [3:0]  COL_CPX     = 4'h3;      // Compare index
  localparam logic [3:0]  COL_STA     = 4'h7;      // Store accumulator
  localparam logic [3:0]  COL_JMP     = 4'hc;      // unconditional_jump_op
  localparam logic [3:0]  COL_JSR     = 4'hd;      // subroutine_call_op
  localparam logic [3:0]  COL_LDX     = 4'he;      // Load index
  localparam logic [3:0]  COL_STX     = 4'hf;      // Store index
  localparam logic [3:0]  COL_TST     = 4'hd;      // negative_zero_test_op
  localparam logic [7:0]  OP_BSR      = 8'had;     // Branch to subroutine
  localparam logic [15:0] RMW_COLS    = 16'hb7d9;  // Legal modify columns
  localparam logic [15:0] CTL_LO_COLS = 16'h000b;  // Legal control, row 8
  localparam logic [15:0] CTL_HI_COLS = 16'hbf80;  // Legal control, row 9

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    AM_IMM, AM_DIR, AM_EXT, AM_REL, AM_IX0, AM_IX1, AM_IX2, AM_BSC, AM_BTB, AM_INH
  } eag_mode_t;

  typedef enum logic [2:0] {
    CL_REGMEM, CL_RMW, CL_BRANCH, CL_BIT, CL_CTRL
  } eag_class_t;

  typedef enum logic [1:0] {
    RS_NONE, RS_ACC, RS_IDX
  } eag_reg_t;

  // Request from the sequencer: opcode, following bytes, context
  typedef struct packed {
    logic [DATA_W-1:0]  opcode;     // Opcode byte
    logic [DATA_W-1:0]  byte1;      // First byte after opcode
    logic [DATA_W-1:0]  byte2;      // Second byte after opcode
    logic [DATA_W-1:0]  index;      // Index register
    logic [ADDR_W-1:0]  pc;         // Address of the opcode
    logic [DATA_W-1:0]  data;       // Byte read at a direct address
  } eag_req_t;

  // Decoded answer back to the sequencer
  typedef struct packed {
    eag_mode_t          mode;              // Addressing mode
    eag_class_t         cls;               // Instruction class
    eag_reg_t           reg_sel;           // Register operand
    logic [1:0]         len;               // Instruction length
    logic [ADDR_W-1:0]  operand_location;  // Effective address
    logic [DATA_W-1:0]  operand_value;     // Immediate operand
    logic [ADDR_W-1:0]  next_pc;           // Next program counter
    logic               branch_taken;      // Branch performed
    logic               mem_read;          // Operand read from memory
    logic               write_back;        // Result stored back
    logic               carry_we;          // Carry flag updated
    logic               carry;             // New carry value
    logic [2:0]         bit_num;           // Bit selected by opcode
    logic               bit_val;           // Set (1) / clear (0) value
    logic               illegal;           // Opcode not in the map
  } eag_dec_t;

endpackage

// ### verilog/eag_effective_address_generator.sv
// Effective address generator: decodes one opcode and its following bytes.
// Assumes the sequencer presents opcode, bytes, index, opcode address and,
// for bit test, the byte read at the direct address, all on mclk_i.
//
// Contract
// - Immediate operand is the byte after opcode
// - Direct: one-byte address, page zero, two bytes
// - Extended: two-byte full address, three bytes
// - Relative: add signed offset only when taken
// - Relative span -126 to +129 from opcode
// - Indexed plain: index is address, one byte
// - Indexed 8-bit: index plus byte, to 510
// - Indexed 16-bit: index plus word, three bytes
// - Bit set/clear: bit in opcode, direct address
// - Bit test: bit, polarity, address, offset decoded
// - Bit test span -125 to +130 from opcode
// - Tested bit copied to carry always
// - Inherent decoded from the opcode alone
// - Ten modes, five classes, 207 legal opcodes
// - Modify class reads, alters, writes back, except the negative/zero test
// - Negative/zero test skips the write-back
// - Jump and subroutine call use no register

`timescale 1ns/1ns

module eag_effective_address_generator (
  // Clock and reset
  input  wire logic               mclk_i,
  input  wire logic               reset_i,
  // Request from the sequencer
  input  wire logic               req_valid_i,
  input  wire eag_pkg::eag_req_t  req_i,
  input  wire logic               cond_true_i,
  // Decoded answer
  output logic                    done_o,
  output eag_pkg::eag_dec_t       dec_o
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Sign-extend a branch offset to the address width
  function automatic logic [eag_pkg::ADDR_W-1:0] sext8(input logic [7:0] off);
    sext8 = {{(eag_pkg::ADDR_W-8){off[7]}}, off};
  endfunction

  // Zero-extend a byte to the address width
  function automatic logic [eag_pkg::ADDR_W-1:0] zext8(input logic [7:0] b);
    zext8 = {{(eag_pkg::ADDR_W-8){1'b0}}, b};
  endfunction

  // Column legal in a row mask
  function automatic logic col_ok(input logic [15:0] mask, input logic [3:0] col);
    col_ok = mask[col];
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  eag_pkg::eag_dec_t  dec_q;        // Registered answer
  eag_pkg::eag_dec_t  dec_d;        // Next answer
  logic               done_q;       // Answer strobe
  logic               done_d;

  // Decode scratch
  logic [3:0]                 row;          // Opcode high nibble
  logic [3:0]                 col;          // Opcode low nibble
  logic [eag_pkg::ADDR_W-1:0] seq_pc;       // Address after instruction
  logic [eag_pkg::ADDR_W-1:0] word12;       // Two following bytes
  logic [eag_pkg::ADDR_W:0]   ix2_sum;      // One bit wider than the bus
  logic [8:0]                 ix1_sum;      // Reaches 0x1fe at most
  logic                       tested_bit;   // Bit read for bit test

  assign row        = req_i.opcode[7:4];
  assign col        = req_i.opcode[3:0];
  // High byte first on the two-byte forms
  assign word12     = {req_i.byte1, req_i.byte2};
  // Sums kept unsigned and one bit wider so no carry is lost
  assign ix1_sum    = {1'b0, req_i.index} + {1'b0, req_i.byte1};
  assign ix2_sum    = {1'b0, word12} + {{(eag_pkg::ADDR_W-7){1'b0}}, req_i.index};
  assign tested_bit = req_i.data[req_i.opcode[3:1]];

  // ****************************************************************
  // Decode
  // ****************************************************************

  // Whole decode happens in one cycle from the presented bytes
  always_comb begin
    dec_d  = dec_q;
    done_d = 1'b0;
    seq_pc = req_i.pc;
    if (req_valid_i) begin
      done_d                = 1'b1;
      // Defaults: inherent control, nothing touched
      dec_d.mode             = eag_pkg::AM_INH;
      dec_d.cls              = eag_pkg::CL_CTRL;
      dec_d.reg_sel          = eag_pkg::RS_NONE;
      dec_d.len              = eag_pkg::LEN_ONE;
      dec_d.operand_location = '0;
      dec_d.operand_value    = '0;
      dec_d.branch_taken     = 1'b0;
      dec_d.mem_read         = 1'b0;
      dec_d.write_back       = 1'b0;
      dec_d.carry_we         = 1'b0;
      dec_d.carry            = 1'b0;
      dec_d.bit_num          = req_i.opcode[3:1];
      dec_d.bit_val          = ~req_i.opcode[0];
      dec_d.illegal          = 1'b0;
      unique case (row)
        // Bit test and branch: address in byte one, offset in byte two
        eag_pkg::ROW_BTB: begin
          dec_d.mode             = eag_pkg::AM_BTB;
          dec_d.cls              = eag_pkg::CL_BIT;
          dec_d.len              = eag_pkg::LEN_THREE;
          dec_d.operand_location = zext8(req_i.byte1);
          dec_d.mem_read         = 1'b1;
          // Even opcode branches on a set bit, odd on a clear bit
          dec_d.branch_taken     = (tested_bit == ~req_i.opcode[0]);
          // Carry follows the bit, taken or not
          dec_d.carry_we         = 1'b1;
          dec_d.carry            = tested_bit;
        end
        // Bit set or clear on a page-zero byte
        eag_pkg::ROW_BSC: begin
          dec_d.mode             = eag_pkg::AM_BSC;
          dec_d.cls              = eag_pkg::CL_BIT;
          dec_d.len              = eag_pkg::LEN_TWO;
          dec_d.operand_location = zext8(req_i.byte1);
          dec_d.mem_read         = 1'b1;
          dec_d.write_back       = 1'b1;
        end
        // Conditional branches; the sequencer judges the condition
        eag_pkg::ROW_REL: begin
          dec_d.mode             = eag_pkg::AM_REL;
          dec_d.cls              = eag_pkg::CL_BRANCH;
          dec_d.len              = eag_pkg::LEN_TWO;
          dec_d.branch_taken     = cond_true_i;
        end
        // Read-modify-write rows
        eag_pkg::ROW_RMW_DIR, eag_pkg::ROW_RMW_A, eag_pkg::ROW_RMW_X,
        eag_pkg::ROW_RMW_IX1, eag_pkg::ROW_RMW_IX0: begin
          dec_d.cls        = eag_pkg::CL_RMW;
          dec_d.illegal    = ~col_ok(eag_pkg::RMW_COLS, col);
          // Test only sets flags, so no store cycle
          dec_d.write_back = (col != eag_pkg::COL_TST);
          dec_d.mem_read   = 1'b1;
          if (row == eag_pkg::ROW_RMW_A) begin
            dec_d.mode     = eag_pkg::AM_INH;
            dec_d.reg_sel  = eag_pkg::RS_ACC;
            dec_d.mem_read = 1'b0;
          end else if (row == eag_pkg::ROW_RMW_X) begin
            dec_d.mode     = eag_pkg::AM_INH;
            dec_d.reg_sel  = eag_pkg::RS_IDX;
            dec_d.mem_read = 1'b0;
          end else if (row == eag_pkg::ROW_RMW_DIR) begin
            dec_d.mode             = eag_pkg::AM_DIR;
            dec_d.len              = eag_pkg::LEN_TWO;
            dec_d.operand_location = zext8(req_i.byte1);
          end else if (row == eag_pkg::ROW_RMW_IX1) begin
            dec_d.mode             = eag_pkg::AM_IX1;
            dec_d.len              = eag_pkg::LEN_TWO;
            dec_d.operand_location = {{(eag_pkg::ADDR_W-9){1'b0}}, ix1_sum};
          end else begin
            dec_d.mode             = eag_pkg::AM_IX0;
            dec_d.operand_location = zext8(req_i.index);
          end
        end
        // Control instructions: one byte, opcode alone
        eag_pkg::ROW_CTL_LO, eag_pkg::ROW_CTL_HI: begin
          dec_d.mode    = eag_pkg::AM_INH;
          dec_d.illegal = (row == eag_pkg::ROW_CTL_LO) ? ~col_ok(eag_pkg::CTL_LO_COLS, col)
                                                       : ~col_ok(eag_pkg::CTL_HI_COLS, col);
        end
        // Register/memory rows
        default: begin
          dec_d.cls      = eag_pkg::CL_REGMEM;
          dec_d.mem_read = 1'b1;
          // Jumps carry no register operand
          if (col == eag_pkg::COL_JMP || col == eag_pkg::COL_JSR)
            dec_d.reg_sel = eag_pkg::RS_NONE;
          else if (col == eag_pkg::COL_CPX || col == eag_pkg::COL_LDX || col == eag_pkg::COL_STX)
            dec_d.reg_sel = eag_pkg::RS_IDX;
          else
            dec_d.reg_sel = eag_pkg::RS_ACC;
          unique case (row)
            eag_pkg::ROW_IMM: begin
              dec_d.len = eag_pkg::LEN_TWO;
              if (req_i.opcode == eag_pkg::OP_BSR) begin
                // Unconditional relative call
                dec_d.mode         = eag_pkg::AM_REL;
                dec_d.cls          = eag_pkg::CL_BRANCH;
                dec_d.reg_sel      = eag_pkg::RS_NONE;
                dec_d.mem_read     = 1'b0;
                dec_d.branch_taken = 1'b1;
              end else begin
                dec_d.mode          = eag_pkg::AM_IMM;
                dec_d.mem_read      = 1'b0;
                dec_d.operand_value = req_i.byte1;
                // A store or jump to a constant has no meaning
                dec_d.illegal = (col == eag_pkg::COL_STA) || (col == eag_pkg::COL_JMP) ||
                                (col == eag_pkg::COL_STX);
              end
            end
            eag_pkg::ROW_DIR: begin
              dec_d.mode             = eag_pkg::AM_DIR;
              dec_d.len              = eag_pkg::LEN_TWO;
              dec_d.operand_location = zext8(req_i.byte1);
            end
            eag_pkg::ROW_EXT: begin
              dec_d.mode             = eag_pkg::AM_EXT;
              dec_d.len              = eag_pkg::LEN_THREE;
              dec_d.operand_location = word12;
            end
            eag_pkg::ROW_IX2: begin
              dec_d.mode             = eag_pkg::AM_IX2;
              dec_d.len              = eag_pkg::LEN_THREE;
              dec_d.operand_location = ix2_sum[eag_pkg::ADDR_W-1:0];
            end
            eag_pkg::ROW_IX1: begin
              dec_d.mode             = eag_pkg::AM_IX1;
              dec_d.len              = eag_pkg::LEN_TWO;
              dec_d.operand_location = {{(eag_pkg::ADDR_W-9){1'b0}}, ix1_sum};
            end
            default: begin
              dec_d.mode             = eag_pkg::AM_IX0;
              dec_d.len              = eag_pkg::LEN_ONE;
              dec_d.operand_location = zext8(req_i.index);
            end
          endcase
        end
      endcase
      // Sequential address, then offset added only on a taken branch
      seq_pc        = req_i.pc + {{(eag_pkg::ADDR_W-2){1'b0}}, dec_d.len};
      dec_d.next_pc = seq_pc;
      if (dec_d.branch_taken) begin
        if (dec_d.mode == eag_pkg::AM_BTB)
          dec_d.next_pc = seq_pc + sext8(req_i.byte2);
        else
          dec_d.next_pc = seq_pc + sext8(req_i.byte1);
      end
      // Only the jump, not the subroutine call, leaves through the effective address instead
      if (dec_d.cls == eag_pkg::CL_REGMEM && col == eag_pkg::COL_JMP)
        dec_d.next_pc = dec_d.operand_location;
    end
  end

  // Register the answer; held until the next request
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      dec_q  <= '0;
      done_q <= 1'b0;
    end else begin
      dec_q  <= dec_d;
      done_q <= done_d;
    end
  end

  assign done_o = done_q;
  assign dec_o  = dec_q;

  // ****************************************************************
  // Checks
  // ****************************************************************

  a_imm_operand_byte: assert property (@(posedge mclk_i) disable iff (reset_i)
    done_o && dec_o.mode == eag_pkg::AM_IMM |-> dec_o.operand_value == $past(req_i.byte1))
    else $error("immediate operand not the byte after the opcode");

  a_direct_page_zero: assert property (@(posedge mclk_i) disable iff (reset_i)
    done_o && dec_o.mode == eag_pkg::AM_DIR |->
      dec_o.operand_location[15:8] == 8'h00 && dec_o.len == eag_pkg::LEN_TWO)
    else $error("direct address outside page zero or wrong length");

  a_extended_word: assert property (@(posedge mclk_i) disable iff (reset_i)
    done_o && dec_o.mode == eag_pkg::AM_EXT |->
      dec_o.operand_location == {$past(req_i.byte1), $past(req_i.byte2)} && dec_o.len == eag_pkg::LEN_THREE)
    else $error("extended address not high byte then low byte");

  a_rel_not_taken: assert property (@(posedge mclk_i) disable iff (reset_i)
    done_o && !dec_o.branch_taken |-> dec_o.next_pc == $past(req_i.pc) + 16'h0002 ||
      dec_o.mode != eag_pkg::AM_REL)
    else $error("untaken branch did not fall through");

  a_rel_span: assert property (@(posedge mclk_i) disable iff (reset_i)
    done_o && dec_o.mode == eag_pkg::AM_REL && dec_o.branch_taken |->
      (dec_o.next_pc - $past(req_i.pc) + 16'h007e) <= 16'h00ff)
    else $error("relative target outside span");

  a_ix0_index: assert property (@(posedge mclk_i) disable iff (reset_i)
    done_o && dec_o.mode == eag_pkg::AM_IX0 |-> dec_o.operand_location == {8'h00, $past(req_i.index)})
    else $error("plain indexed address not the index register");

  a_ix1_sum: assert property (@(posedge mclk_i) disable iff (reset_i)
    done_o && dec_o.mode == eag_pkg::AM_IX1 |->
      dec_o.operand_location == {8'h00, $past(req_i.index)} + {8'h00, $past(req_i.byte1)})
    else $error("8-bit indexed sum wrong");

  a_btb_span: assert property (@(posedge mclk_i) disable iff (reset_i)
    done_o && dec_o.mode == eag_pkg::AM_BTB && dec_o.branch_taken |->
      (dec_o.next_pc - $past(req_i.pc) + 16'h007d) <= 16'h00ff)
    else $error("bit test target outside span");

  a_btb_carry: assert property (@(posedge mclk_i) disable iff (reset_i)
    done_o && dec_o.mode == eag_pkg::AM_BTB |->
      dec_o.carry_we && dec_o.carry == $past(req_i.data[req_i.opcode[3:1]]))
    else $error("tested bit not copied to carry");

  a_test_no_store: assert property (@(posedge mclk_i) disable iff (reset_i)
    done_o && dec_o.cls == eag_pkg::CL_RMW && $past(req_i.opcode[3:0]) == eag_pkg::COL_TST |->
      !dec_o.write_back)
    else $error("negative/zero test wrote back");

  a_jump_no_reg: assert property (@(posedge mclk_i) disable iff (reset_i)
    done_o && dec_o.cls == eag_pkg::CL_REGMEM &&
      ($past(req_i.opcode[3:0]) == eag_pkg::COL_JMP || $past(req_i.opcode[3:0]) == eag_pkg::COL_JSR) |->
      dec_o.reg_sel == eag_pkg::RS_NONE)
    else $error("jump given a register operand");

  a_ix2_sum: assert property (@(posedge mclk_i) disable iff (reset_i)
    done_o && dec_o.mode == eag_pkg::AM_IX2 |-> dec_o.len == eag_pkg::LEN_THREE &&
      dec_o.operand_location == {$past(req_i.byte1), $past(req_i.byte2)} + {8'h00, $past(req_i.index)})
    else $error("16-bit indexed sum wrong");

  a_bsc_page_zero: assert property (@(posedge mclk_i) disable iff (reset_i)
    done_o && dec_o.mode == eag_pkg::AM_BSC |-> dec_o.operand_location == {8'h00, $past(req_i.byte1)} &&
      dec_o.len == eag_pkg::LEN_TWO && dec_o.bit_num == $past(req_i.opcode[3:1]))
    else $error("bit set/clear address or bit wrong");

  a_btb_decode: assert property (@(posedge mclk_i) disable iff (reset_i)
    done_o && dec_o.mode == eag_pkg::AM_BTB |-> dec_o.len == eag_pkg::LEN_THREE &&
      dec_o.operand_location == {8'h00, $past(req_i.byte1)} && dec_o.bit_num == $past(req_i.opcode[3:1]))
    else $error("bit test fields wrong");

  a_inherent_one_byte: assert property (@(posedge mclk_i) disable iff (reset_i)
    done_o && dec_o.mode == eag_pkg::AM_INH |-> dec_o.len == eag_pkg::LEN_ONE && !dec_o.mem_read)
    else $error("inherent form not one byte");

  a_modify_store: assert property (@(posedge mclk_i) disable iff (reset_i)
    done_o && dec_o.cls == eag_pkg::CL_RMW && $past(req_i.opcode[3:0]) != eag_pkg::COL_TST |->
      dec_o.write_back)
    else $error("modify instruction did not store back");

  a_done_one_cycle: assert property (@(posedge mclk_i) disable iff (reset_i)
    req_valid_i |=> done_o)
    else $error("answer not one cycle after request");

endmodule

// ### bench/eag_mem_model.sv
// Behavioural program and data memory for the address generator bench.
// Assumes one bench write port and reads that settle without a clock.
`timescale 1ns/1ns
module eag_mem_model (
  // Clock and write port
  input  wire logic        mclk_i,
  input  wire logic        we_i,
  input  wire logic [15:0] wa_i,
  input  wire logic [7:0]  wd_i,
  // Fetch window at the opcode address
  input  wire logic [15:0] pc_i,
  output logic      [7:0]  op_o,
  output logic      [7:0]  b1_o,
  output logic      [7:0]  b2_o,
  output logic      [7:0]  dat_o
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0] mem [0:65535];  // Whole space; unwritten bytes stay unknown
  // Store on the rising edge
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[wa_i] <= wd_i;
    end
  end
  // Opcode, the two bytes after it, and the page-zero byte named by byte one
  assign op_o  = mem[pc_i];
  assign b1_o  = mem[pc_i + 16'h0001];
  assign b2_o  = mem[pc_i + 16'h0002];
  assign dat_o = mem[{8'h00, b1_o}];
endmodule

// ### bench/eag_effective_address_generator_test.sv
// Self-checking bench for the effective address generator.
// Assumes the memory model supplies the opcode, both following bytes and the data byte of a request.
`timescale 1ns/1ns
module eag_effective_address_generator_test;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  typedef struct packed {
    logic [7:0] op, b1, b2, x;
    logic [15:0] pc;
    logic [7:0] d;
    logic [3:0] c, md, ln;
    logic [15:0] ea, np;
    logic [3:0] fl, fm;
  } eag_row_t;
  logic mclk_i = 1'b0;                  // Machine clock
  logic reset_i = 1'b1;                 // Core reset
  logic vld = 1'b0, cond = 1'b0, we = 1'b0;
  logic [15:0] wa = 16'h0000, pc = 16'h0000;
  logic [7:0] wd = 8'h00, x = 8'h00, op, b1, b2, dat;
  logic done;
  eag_pkg::eag_dec_t dec;
  eag_pkg::eag_req_t req;
  eag_row_t r;
  int n_errors = 0, num_checks = 0;
  // Cases: op b1 b2 x, pc, data, cond mode len, ea, next, flags (wb rd c ill), mask
  eag_row_t rows [21] = '{
    108'ha6550000_0100_00_002_0000_0102_01, 108'hb6800000_0100_00_012_0080_0102_01,
    108'hc6123400_0100_00_023_1234_0103_01, 108'hf60000ff_0100_00_041_00ff_0101_01,
    108'he6ff00ff_0100_00_052_01fe_0102_01, 108'hde1234ff_0100_00_063_1333_0103_01,
    108'h20800000_0200_00_132_0000_0182_00, 108'h227f0000_0200_00_132_0000_0281_00,
    108'h227f0000_0200_00_032_0000_0202_00, 108'h10400000_0100_00_072_0040_0102_cd,
    108'h1f400000_0100_00_072_0040_0102_cd, 108'h01408000_0300_00_083_0040_0283_03,
    108'h0e407f00_0300_80_083_0040_0382_23, 108'h00407f00_0300_00_083_0040_0303_03,
    108'h4c000000_0100_00_091_0000_0101_8d, 108'h3d400000_0100_00_012_0040_0102_4d,
    108'h3c400000_0100_00_012_0040_0102_cd, 108'hcc123400_0100_00_023_1234_1234_01,
    108'hbd400000_0100_00_012_0040_0102_01, 108'hae070000_0100_00_002_0000_0102_01,
    108'ha7000000_0400_00_002_0000_0402_01};
  // Request follows the bytes the memory holds at pc
  assign req = '{opcode: op, byte1: b1, byte2: b2, index: x, pc: pc, data: dat};
  always #10 mclk_i = ~mclk_i;          // 50 MHz
  eag_mem_model u_mem (.mclk_i(mclk_i), .we_i(we), .wa_i(wa), .wd_i(wd), .pc_i(pc),
                       .op_o(op), .b1_o(b1), .b2_o(b2), .dat_o(dat));
  eag_effective_address_generator u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .req_valid_i(vld),
                                         .req_i(req), .cond_true_i(cond), .done_o(done), .dec_o(dec));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic cmp4(input logic [3:0] g, input logic [3:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    #2 we = 1'b1;
    wa = a;
    wd = d;
  endtask
  // Load the bytes, then one request; the answer is due one edge later
  task automatic go(input eag_row_t q);
    wr(q.pc, q.op);
    wr(q.pc + 16'h0001, q.b1);
    wr(q.pc + 16'h0002, q.b2);
    wr({8'h00, q.b1}, q.d);
    @(posedge mclk_i);
    #2 we = 1'b0;
    pc = q.pc;
    x = q.x;
    cond = q.c[0];
    vld = 1'b1;
    @(posedge mclk_i);
    #2 vld = 1'b0;
    cmp4({3'h0, done}, 4'h1);
  endtask
  // Register choice follows the opcode column
  function automatic logic [1:0] rsel(input logic [7:0] o);
    if (o[3:0] inside {4'h3, 4'he, 4'hf}) return eag_pkg::RS_IDX;
    if (o[3:0] inside {4'hc, 4'hd}) return eag_pkg::RS_NONE;
    return eag_pkg::RS_ACC;
  endfunction
  // Class follows the opcode row; the relative call sits in the immediate row
  function automatic logic [3:0] cls_of(input logic [7:0] o);
    if (o == 8'had || o[7:4] == 4'h2) return {1'b0, eag_pkg::CL_BRANCH};
    if (o[7:4] < 4'h2) return {1'b0, eag_pkg::CL_BIT};
    if (o[7:4] < 4'h8) return {1'b0, eag_pkg::CL_RMW};
    if (o[7:4] < 4'ha) return {1'b0, eag_pkg::CL_CTRL};
    return {1'b0, eag_pkg::CL_REGMEM};
  endfunction
  task automatic test_done();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge mclk_i);
    #2 cmp4({2'h0, done, dec === '0}, 4'h1);
    reset_i = 1'b0;
    for (int i = 0; i < 20; i++) begin
      r = rows[i];
      go(r);
      cmp4(dec.mode, r.md);
      cmp4({2'h0, dec.len}, r.ln);
      cmp16(dec.next_pc, r.np);
      cmp4({dec.write_back, dec.mem_read, dec.carry, dec.illegal} & r.fm, r.fl & r.fm);
      if (!(r.md inside {4'h0, 4'h3, 4'h9})) cmp16(dec.operand_location, r.ea);
      if (r.md == 4'h0) cmp16({8'h00, dec.operand_value}, {8'h00, r.b1});
      if (r.op >= 8'ha0) cmp4({2'h0, dec.reg_sel}, {2'h0, rsel(r.op)});
      if (r.md inside {4'h7, 4'h8}) cmp4({dec.bit_val, dec.bit_num}, {~r.op[0], r.op[3:1]});
      cmp4({1'b0, dec.cls}, cls_of(r.op));
      if (r.md == 4'h8) cmp4({3'h0, dec.carry_we}, 4'h1);
      $display("case %0d done", i);
    end
    // Back to back: unmapped opcode, then extended load, then the hold
    go(rows[2]);
    go(rows[20]);
    @(posedge mclk_i);
    #2 vld = 1'b1;
    pc = 16'h0400;
    @(posedge mclk_i);
    #2 pc = 16'h0100;
    cmp4({2'h0, done, dec.illegal}, 4'h3);
    @(posedge mclk_i);
    #2 vld = 1'b0;
    cmp16(dec.operand_location, 16'h1234);
    cmp4({3'h0, done}, 4'h1);
    @(posedge mclk_i);
    #2 cmp4({2'h0, done, dec.mode == eag_pkg::AM_EXT}, 4'h1);
    $display("back to back done");
    // Reset in mid-run clears the answer; decoding resumes after it
    reset_i = 1'b1;
    @(posedge mclk_i);
    #2 cmp4({2'h0, done, dec === '0}, 4'h1);
    reset_i = 1'b0;
    go(rows[1]);
    cmp16(dec.operand_location, 16'h0080);
    $display("reset done");
    test_done();
  end
  // Hang guard
  initial begin
    #1000000;
    n_errors++;
    test_done();
  end
endmodule
